// ==== rtl/pld_cfg.svh ====
// Purpose: Constants of the PLL lock detector and status pin selector
// Assumes: Included by the design modules and the bench
// Notes: Register indexes are word indexes; byte address is four times the index
//
// Behaviour
// - Selector 0 holds the status pin low, selector 1 holds it high.
// - Selectors 2-6 drive settled, instant, carrier sense, calibration done, fault, active low.
// - Selectors 7-13 route the clocks, 14 calibration comparator, 15 frequency comparator.
// - Comparison window spans 2 prescaler cycles, or 4 when the width bit is set.
// - Mode bit 0 selects counter restart, 1 selects up/down counting.
// - Accuracy picks lock/unlock thresholds 127/111 up to 1023/1007; hysteresis between them.
`ifndef PLD_CFG_SVH
`define PLD_CFG_SVH

`define PLD_IDX_CFG 10'h015
`define PLD_IDX_STATUS 10'h020
`define PLD_IDX_IRQ 10'h021
`define PLD_IDX_MASK 10'h022
`define PLD_CFG_RESET 8'h00

`define PLD_SEL_ZERO 4'h0
`define PLD_SEL_ONE 4'h1
`define PLD_SEL_SETTLED 4'h2
`define PLD_SEL_INSTANT 4'h3
`define PLD_SEL_CARRIER 4'h4
`define PLD_SEL_CAL_DONE 4'h5
`define PLD_SEL_FAULT 4'h6
`define PLD_SEL_CRYSTAL 4'h7
`define PLD_SEL_REF 4'h8
`define PLD_SEL_FILTER 4'h9
`define PLD_SEL_DECIM 4'ha
`define PLD_SEL_PRE 4'hb
`define PLD_SEL_DSIGMA 4'hc
`define PLD_SEL_MODEM 4'hd
`define PLD_SEL_OSC_CMP 4'he
`define PLD_SEL_FREQ_CMP 4'hf

`define PLD_LOCK_THR0 10'h07f
`define PLD_LOCK_THR1 10'h0ff
`define PLD_LOCK_THR2 10'h1ff
`define PLD_LOCK_THR3 10'h3ff
`define PLD_UNLOCK_THR0 10'h06f
`define PLD_UNLOCK_THR1 10'h0ef
`define PLD_UNLOCK_THR2 10'h1ef
`define PLD_UNLOCK_THR3 10'h3ef

`define PLD_WIN_NARROW 3'h2
`define PLD_WIN_WIDE 3'h4

`define PLD_RESP_OKAY 2'h0
`define PLD_RESP_SLVERR 2'h2

`endif

// ==== rtl/pld_pkg.sv ====
// Purpose: Types of the PLL lock detector and status pin selector
// Assumes: Nothing beyond the constants header
// Notes: All module state is held in the structs below
`default_nettype none
package pld_pkg;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic ref_clk;
    logic pre_clk;
    logic div_clk;
    logic crystal_clock;
    logic filter_clk;
    logic decimator_clock;
    logic delta_sigma_clock;
    logic modem_clock;
    logic oscillator_calibration_comparator;
    logic freq_comp;
    logic carrier_sense;
    logic cal_done;
    logic sequencing_fault_flag;
  } pld_pins_t;

  typedef struct packed {
    logic [3:0] sel;
    logic wide;
    logic updown;
    logic [1:0] acc;
  } pld_cfg_t;

  typedef struct packed {
    logic lost;
    logic gained;
  } pld_irq_t;

  typedef enum logic [1:0] {W_IDLE, W_WAIT_DIV, W_WAIT_REF} pld_wst_t;

  // ****************************************
  // Module state
  // ****************************************
  typedef struct packed {
    logic [9:0] count;
    logic settled;
    logic gained;
    logic lost;
  } pld_cnt_st_t;

  typedef struct packed {
    pld_pins_t s1;
    pld_pins_t s2;
    logic ref_q;
    logic pre_q;
    logic div_q;
    pld_wst_t wst;
    logic [2:0] win_cnt;
    logic win_wide;
    logic hit;
    logic miss;
    logic instant;
    pld_cfg_t cfg;
    pld_irq_t irq_st;
    pld_irq_t irq_mask;
    logic aw_held;
    logic [9:0] aw_idx;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pin;
  } pld_core_st_t;

endpackage : pld_pkg
`default_nettype wire

// ==== rtl/pld_lock_counter.sv ====
// Purpose: Lock counter with selectable thresholds and hysteresis
// Assumes: hit and miss are one-cycle pulses, never together
// Notes: Count saturates at the lock threshold so hysteresis is 16 misses in up/down mode; in restart mode one miss unlocks
`include "pld_cfg.svh"
`default_nettype none
module pld_lock_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hit,
  input wire logic miss,
  input wire logic updown,
  input wire logic [1:0] acc,
  output logic [9:0] count,
  output logic settled,
  output logic gained,
  output logic lost
);
  import pld_pkg::*;

  function automatic logic [9:0] lock_thr(input logic [1:0] a);
    unique case (a)
      2'h0: lock_thr = `PLD_LOCK_THR0;
      2'h1: lock_thr = `PLD_LOCK_THR1;
      2'h2: lock_thr = `PLD_LOCK_THR2;
      2'h3: lock_thr = `PLD_LOCK_THR3;
    endcase
  endfunction : lock_thr

  function automatic logic [9:0] unlock_thr(input logic [1:0] a);
    unique case (a)
      2'h0: unlock_thr = `PLD_UNLOCK_THR0;
      2'h1: unlock_thr = `PLD_UNLOCK_THR1;
      2'h2: unlock_thr = `PLD_UNLOCK_THR2;
      2'h3: unlock_thr = `PLD_UNLOCK_THR3;
    endcase
  endfunction : unlock_thr

  pld_cnt_st_t r;
  pld_cnt_st_t n;
  logic [9:0] hi;
  logic [9:0] lo;

  assign hi = lock_thr(acc);
  assign lo = unlock_thr(acc);

  // ****************************************
  // Counter and lock decision
  // ****************************************
  always_comb begin
    n = r;
    n.gained = 1'b0;
    n.lost = 1'b0;
    if (hit) begin
      n.count = (r.count >= hi) ? hi : r.count + 10'h001;
    end else if (miss) begin
      if (!updown) begin
        n.count = '0;
      end else if (r.count != '0) begin
        n.count = r.count - 10'h001;
      end
    end
    if (!r.settled && n.count >= hi) begin
      n.settled = 1'b1;
      n.gained = 1'b1;
    end else if (r.settled && n.count <= lo) begin
      n.settled = 1'b0;
      n.lost = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign count = r.count;
  assign settled = r.settled;
  assign gained = r.gained;
  assign lost = r.lost;

  // ****************************************
  // Checks
  // ****************************************
  a_restart_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    miss && !updown |=> count == '0) else $error("restart mode miss did not clear count");
  a_updown_step: assert property (@(posedge aclk) disable iff (!aresetn)
    miss && updown && count != '0 |=> count == $past(count) - 10'h001) else $error("up/down miss did not decrement");
  a_updown_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    miss && updown && count == '0 |=> count == '0) else $error("count went below zero");
  a_hit_step: assert property (@(posedge aclk) disable iff (!aresetn)
    hit && count < hi |=> count == $past(count) + 10'h001) else $error("hit did not increment count");
  a_lock_declare: assert property (@(posedge aclk) disable iff (!aresetn)
    !settled && hit && count == hi - 10'h001 && $stable(acc) |=> settled && gained)
    else $error("lock not declared at threshold");
  a_lock_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    settled && miss && count == lo + 10'h001 |=> !settled && lost) else $error("lock not dropped at lower count");

endmodule : pld_lock_counter
`default_nettype wire

// ==== rtl/pld_lock_status.sv ====
// Purpose: PLL lock detector window, register file and status pin selector
// Assumes: All pin sources are asynchronous and sampled through two flops
// Notes: AXI4-Lite slave, one write and one read in flight; status pin is registered
//
// Decided for this implementation: the AXI4-Lite register port.
`include "pld_cfg.svh"
`default_nettype none
module pld_lock_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pld_pkg::pld_pins_t pins_async,
  output logic status_pin,
  output logic irq
);
  import pld_pkg::*;

  function automatic logic reg_known(input logic [9:0] idx);
    reg_known = (idx == `PLD_IDX_CFG) || (idx == `PLD_IDX_STATUS) ||
                (idx == `PLD_IDX_IRQ) || (idx == `PLD_IDX_MASK);
  endfunction : reg_known

  function automatic logic [2:0] win_len(input logic wide);
    win_len = wide ? `PLD_WIN_WIDE : `PLD_WIN_NARROW;
  endfunction : win_len

  pld_core_st_t r;
  pld_core_st_t n;
  logic [9:0] lock_count;
  logic pll_settled_flag;
  logic lock_gained;
  logic lock_lost;
  logic ref_rise;
  logic pre_rise;
  logic div_rise;
  logic other_rise;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_v;
  logic w_v;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic [7:0] wr_byte;
  logic wr_strb;
  pld_irq_t irq_ev;
  pld_irq_t irq_clr;

  // ****************************************
  // Lock counter
  // ****************************************
  pld_lock_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .hit(r.hit),
    .miss(r.miss),
    .updown(r.cfg.updown),
    .acc(r.cfg.acc),
    .count(lock_count),
    .settled(pll_settled_flag),
    .gained(lock_gained),
    .lost(lock_lost)
  );

  // ****************************************
  // Edge detection on synchronised pins
  // ****************************************
  assign ref_rise = r.s2.ref_clk & ~r.ref_q;
  assign pre_rise = r.s2.pre_clk & ~r.pre_q;
  assign div_rise = r.s2.div_clk & ~r.div_q;
  assign other_rise = (r.wst == W_WAIT_DIV) ? div_rise : ref_rise;

  // ****************************************
  // Bus handshakes
  // ****************************************
  assign s_axi_awready = !r.aw_held && !r.bvalid;
  assign s_axi_wready = !r.w_held && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign aw_v = r.aw_held || aw_take;
  assign w_v = r.w_held || w_take;
  assign wr_idx = r.aw_held ? r.aw_idx : s_axi_awaddr[11:2];
  assign wr_byte = r.w_held ? r.wdata : s_axi_wdata[7:0];
  assign wr_strb = r.w_held ? r.wstrb0 : s_axi_wstrb[0];
  assign rd_idx = s_axi_araddr[11:2];
  assign irq_ev = '{lost: lock_lost, gained: lock_gained};
  assign irq_clr = (ar_take && rd_idx == `PLD_IDX_IRQ) ? r.irq_st : '0;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = r;
    n.s1 = pins_async;
    n.s2 = r.s1;
    n.ref_q = r.s2.ref_clk;
    n.pre_q = r.s2.pre_clk;
    n.div_q = r.s2.div_clk;
    n.hit = 1'b0;
    n.miss = 1'b0;

    // Window: started by whichever edge comes first
    unique case (r.wst)
      W_IDLE: begin
        n.win_cnt = '0;
        n.win_wide = r.cfg.wide;
        if (ref_rise && div_rise) begin
          n.hit = 1'b1;
        end else if (ref_rise) begin
          n.wst = W_WAIT_DIV;
        end else if (div_rise) begin
          n.wst = W_WAIT_REF;
        end
      end
      W_WAIT_DIV, W_WAIT_REF: begin
        if (other_rise) begin
          n.hit = 1'b1;
          n.wst = W_IDLE;
        end else if (pre_rise) begin
          if (r.win_cnt == win_len(r.win_wide) - 3'h1) begin
            n.miss = 1'b1;
            n.wst = W_IDLE;
          end else begin
            n.win_cnt = r.win_cnt + 3'h1;
          end
        end
      end
      default: n.wst = W_IDLE;
    endcase
    if (r.hit) begin
      n.instant = 1'b1;
    end else if (r.miss) begin
      n.instant = 1'b0;
    end

    // Status pin selector
    unique case (r.cfg.sel)
      `PLD_SEL_ZERO: n.pin = 1'b0;
      `PLD_SEL_ONE: n.pin = 1'b1;
      `PLD_SEL_SETTLED: n.pin = !pll_settled_flag;
      `PLD_SEL_INSTANT: n.pin = !r.instant;
      `PLD_SEL_CARRIER: n.pin = !r.s2.carrier_sense;
      `PLD_SEL_CAL_DONE: n.pin = !r.s2.cal_done;
      `PLD_SEL_FAULT: n.pin = !r.s2.sequencing_fault_flag;
      `PLD_SEL_CRYSTAL: n.pin = r.s2.crystal_clock;
      `PLD_SEL_REF: n.pin = r.s2.ref_clk;
      `PLD_SEL_FILTER: n.pin = r.s2.filter_clk;
      `PLD_SEL_DECIM: n.pin = r.s2.decimator_clock;
      `PLD_SEL_PRE: n.pin = r.s2.pre_clk;
      `PLD_SEL_DSIGMA: n.pin = r.s2.delta_sigma_clock;
      `PLD_SEL_MODEM: n.pin = r.s2.modem_clock;
      `PLD_SEL_OSC_CMP: n.pin = r.s2.oscillator_calibration_comparator;
      `PLD_SEL_FREQ_CMP: n.pin = r.s2.freq_comp;
    endcase

    // Sticky events, set wins over read clear
    n.irq_st = (r.irq_st & ~irq_clr) | irq_ev;

    // Write channel
    if (aw_take) begin
      n.aw_held = 1'b1;
      n.aw_idx = s_axi_awaddr[11:2];
    end
    if (w_take) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (aw_v && w_v) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = reg_known(wr_idx) ? `PLD_RESP_OKAY : `PLD_RESP_SLVERR;
      if (wr_strb && wr_idx == `PLD_IDX_CFG) begin
        n.cfg = wr_byte;
      end
      if (wr_strb && wr_idx == `PLD_IDX_MASK) begin
        n.irq_mask = wr_byte[1:0];
      end
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // Read channel
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_take) begin
      n.rvalid = 1'b1;
      n.rresp = reg_known(rd_idx) ? `PLD_RESP_OKAY : `PLD_RESP_SLVERR;
      n.rdata = '0;
      if (rd_idx == `PLD_IDX_CFG) begin
        n.rdata[7:0] = r.cfg;
      end
      if (rd_idx == `PLD_IDX_STATUS) begin
        n.rdata = {6'h00, lock_count, 14'h0000, r.instant, pll_settled_flag};
      end
      if (rd_idx == `PLD_IDX_IRQ) begin
        n.rdata[1:0] = r.irq_st;
      end
      if (rd_idx == `PLD_IDX_MASK) begin
        n.rdata[1:0] = r.irq_mask;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.cfg <= `PLD_CFG_RESET;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign status_pin = r.pin;
  assign irq = |(r.irq_st & r.irq_mask);

  // ****************************************
  // Checks
  // ****************************************
  a_pin_low: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_ZERO |=> !status_pin) else $error("pin not low for selector zero");
  a_pin_high: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_ONE |=> status_pin) else $error("pin not high for selector one");
  a_pin_settled: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_SETTLED |=> status_pin == !$past(pll_settled_flag))
    else $error("pin does not show settled flag active low");
  a_pin_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_FAULT |=> status_pin == !$past(r.s2.sequencing_fault_flag))
    else $error("pin does not show fault flag active low");
  a_pin_prescaler: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_PRE |=> status_pin == $past(r.s2.pre_clk)) else $error("pin does not carry prescaler clock");
  a_pin_freq_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_FREQ_CMP |=> status_pin == $past(r.s2.freq_comp))
    else $error("pin does not carry frequency comparator");
  a_pin_instant: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_INSTANT |=> status_pin == !$past(r.instant))
    else $error("pin does not show instant flag active low");
  a_pin_carrier: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_CARRIER |=> status_pin == !$past(r.s2.carrier_sense))
    else $error("pin does not show carrier sense active low");
  a_pin_cal_done: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_CAL_DONE |=> status_pin == !$past(r.s2.cal_done))
    else $error("pin does not show calibration done active low");
  a_pin_crystal: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_CRYSTAL |=> status_pin == $past(r.s2.crystal_clock))
    else $error("pin does not carry crystal clock");
  a_pin_ref: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_REF |=> status_pin == $past(r.s2.ref_clk))
    else $error("pin does not carry reference clock");
  a_pin_filter: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_FILTER |=> status_pin == $past(r.s2.filter_clk))
    else $error("pin does not carry filter clock");
  a_pin_decim: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_DECIM |=> status_pin == $past(r.s2.decimator_clock))
    else $error("pin does not carry decimation clock");
  a_pin_dsigma: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_DSIGMA |=> status_pin == $past(r.s2.delta_sigma_clock))
    else $error("pin does not carry delta sigma clock");
  a_pin_modem: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_MODEM |=> status_pin == $past(r.s2.modem_clock))
    else $error("pin does not carry modem clock");
  a_pin_osc_cmp: assert property (@(posedge aclk) disable iff (!aresetn)
    r.cfg.sel == `PLD_SEL_OSC_CMP |=> status_pin == $past(r.s2.oscillator_calibration_comparator))
    else $error("pin does not carry calibration comparator");

  // ****************************************
  // Window checks
  // ****************************************
  a_win_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    r.wst != W_IDLE |-> r.win_cnt < win_len(r.win_wide)) else $error("window count beyond window width");
  a_win_expire: assert property (@(posedge aclk) disable iff (!aresetn)
    r.wst != W_IDLE && !other_rise && pre_rise && r.win_cnt == win_len(r.win_wide) - 3'h1
    |=> r.miss && r.wst == W_IDLE) else $error("window did not expire at its width");
  a_win_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    r.wst != W_IDLE && other_rise |=> r.hit && r.wst == W_IDLE)
    else $error("edge inside window did not count as hit");
  a_same_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    r.wst == W_IDLE && ref_rise && div_rise |=> r.hit && r.wst == W_IDLE)
    else $error("simultaneous edges did not count as hit");

endmodule : pld_lock_status
`default_nettype wire

// ==== tb/pld_pin_model.sv ====
// Purpose: Far side pin sources of the lock detector
// Assumes: Tasks are called just after a rising aclk edge
// Notes: Each level is held three cycles so the synchronisers see every edge
`default_nettype none
module pld_pin_model (
  input wire logic aclk,
  output var pld_pkg::pld_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import pld_pkg::*;

  initial pins = '0;

  task automatic lv(input logic r, input logic d, input logic p);
    pld_pins_t v;
    v = pins;
    v.ref_clk = r;
    v.div_clk = d;
    v.pre_clk = p;
    pins <= v;
    repeat (3) @(posedge aclk);
  endtask : lv

  task automatic set_src(input int b, input logic val);
    pld_pins_t v;
    v = pins;
    v[b] = val;
    pins <= v;
    repeat (3) @(posedge aclk);
  endtask : set_src

  // Reference and divider rise together
  task automatic hit_pair();
    lv(1'b1, 1'b1, 1'b0);
    lv(1'b0, 1'b0, 1'b0);
  endtask : hit_pair

  // Reference rises, divider never follows
  task automatic miss_pair();
    lv(1'b1, 1'b0, 1'b0);
    repeat (4) begin
      lv(1'b1, 1'b0, 1'b1);
      lv(1'b1, 1'b0, 1'b0);
    end
    lv(1'b0, 1'b0, 1'b0);
  endtask : miss_pair

  // Divider lags by three prescaler rises, then the window is flushed
  task automatic late_pair();
    lv(1'b1, 1'b0, 1'b0);
    repeat (3) begin
      lv(1'b1, 1'b0, 1'b1);
      lv(1'b1, 1'b0, 1'b0);
    end
    lv(1'b1, 1'b1, 1'b0);
    repeat (4) begin
      lv(1'b1, 1'b1, 1'b1);
      lv(1'b1, 1'b1, 1'b0);
    end
    lv(1'b0, 1'b0, 1'b0);
  endtask : late_pair
endmodule : pld_pin_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench of the lock detector and status pin
// Assumes: AXI4-Lite master tasks, pin model drives the sources
// Notes: Registers reached at four times the word index
`include "pld_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pld_pkg::*;
  localparam logic [11:0] A_CFG = {`PLD_IDX_CFG, 2'b00};
  localparam logic [11:0] A_ST = {`PLD_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_IRQ = {`PLD_IDX_IRQ, 2'b00};
  localparam logic [11:0] A_MSK = {`PLD_IDX_MASK, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, status_pin, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  pld_pins_t pins;
  int mismatches, samples_checked;

  pld_lock_status i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins_async(pins),
    .status_pin(status_pin), .irq(irq));
  pld_pin_model i_pins (.aclk(aclk), .pins(pins));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask : settle

  task automatic complete_run();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(A_CFG);
    chk("cfg reset", rd_data, 32'h0000_0000);
    chk("pin reset", status_pin, 32'h0);
    chk("irq reset", irq, 32'h0);
    rd(12'hffc);
    chk("unmapped rresp", rd_resp, 32'h2);
    wr(12'hffc, 32'h0000_00ff);
    chk("unmapped bresp", wr_resp, 32'h2);
    wstrb <= 4'he;
    wr(A_CFG, 32'h0000_00ff);
    wstrb <= 4'hf;
    chk("strobe bresp", wr_resp, 32'h0);
    rd(A_CFG);
    chk("strobe off", rd_data, 32'h0000_0000);
  endtask : t_reset

  task automatic t_low();
    wr(A_CFG, 32'h0000_0010);
    settle();
    chk("sel one", status_pin, 32'h1);
    wr(A_CFG, 32'h0000_0000);
    settle();
    chk("sel zero", status_pin, 32'h0);
    for (int k = 2; k <= 6; k++) begin
      wr(A_CFG, 32'(k << 4));
      settle();
      chk("flag idle", status_pin, 32'h1);
      if (k >= 4) begin
        i_pins.set_src(6 - k, 1'b1);
        settle();
        chk("flag set", status_pin, 32'h0);
        i_pins.set_src(6 - k, 1'b0);
      end
    end
  endtask : t_low

  task automatic t_route();
    int map [9] = '{9, 12, 8, 7, 11, 6, 5, 4, 3};
    for (int k = 0; k < 9; k++) begin
      wr(A_CFG, 32'((k + 7) << 4));
      i_pins.set_src(map[k], 1'b1);
      settle();
      chk("route high", status_pin, 32'h1);
      i_pins.set_src(map[k], 1'b0);
      settle();
      chk("route low", status_pin, 32'h0);
    end
  endtask : t_route

  task automatic t_lock();
    int thr;
    for (int acc = 0; acc < 4; acc++) begin
      thr = (128 << acc) - 1;
      wr(A_CFG, 32'h20 | acc);
      i_pins.miss_pair();
      repeat (thr - 1) i_pins.hit_pair();
      settle();
      rd(A_ST);
      chk("below lock", rd_data, (thr - 1) << 16 | 2);
      i_pins.hit_pair();
      settle();
      rd(A_ST);
      chk("at lock", rd_data, thr << 16 | 3);
      chk("pin locked", status_pin, 32'h0);
      i_pins.miss_pair();
      settle();
      rd(A_ST);
      chk("restart miss", rd_data, 32'h0);
      chk("pin unlocked", status_pin, 32'h1);
    end
    chk("irq masked", irq, 32'h0);
    wr(A_MSK, 32'h3);
    rd(A_MSK);
    chk("mask read", rd_data, 32'h3);
    settle();
    chk("irq raised", irq, 32'h1);
    rd(A_IRQ);
    chk("irq events", rd_data, 32'h3);
    chk("irq cleared", irq, 32'h0);
    rd(A_IRQ);
    chk("irq reread", rd_data, 32'h0);
  endtask : t_lock

  task automatic t_updown();
    wr(A_CFG, 32'h24);
    i_pins.miss_pair();
    i_pins.miss_pair();
    i_pins.hit_pair();
    settle();
    rd(A_ST);
    chk("floor zero", rd_data[25:16], 32'd1);
    repeat (126) i_pins.hit_pair();
    settle();
    rd(A_ST);
    chk("updown lock", rd_data, 32'd127 << 16 | 3);
    repeat (15) i_pins.miss_pair();
    settle();
    rd(A_ST);
    chk("hysteresis", rd_data, 32'd112 << 16 | 1);
    i_pins.miss_pair();
    settle();
    rd(A_ST);
    chk("unlock", rd_data, 32'd111 << 16);
  endtask : t_updown

  task automatic t_width();
    for (int w = 0; w < 2; w++) begin
      wr(A_CFG, 32'h20 | (w << 3));
      i_pins.miss_pair();
      i_pins.hit_pair();
      i_pins.hit_pair();
      i_pins.late_pair();
      settle();
      rd(A_ST);
      chk("window width", rd_data[25:16], w ? 32'd3 : 32'd0);
    end
    wr(A_CFG, 32'h30);
    settle();
    chk("pin instant", status_pin, 32'h0);
    i_pins.miss_pair();
    settle();
    chk("pin no instant", status_pin, 32'h1);
  endtask : t_width

  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    complete_run();
  end

  initial begin
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= '0;
    awaddr <= '0;
    araddr <= '0;
    wdata <= '0;
    wstrb <= 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_low();
    t_route();
    t_lock();
    t_updown();
    t_width();
    complete_run();
  end
endmodule : tb
`default_nettype wire
